// >>> inc/mfit_pkg.sv
/*
 * constants, register map and state type of the module flag, interrupt
 * and control-response block.
 * assumes a 125 mhz register clock and an axi4-lite master on the bus side.
 */
`default_nettype none

package mfit_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ           = 125_000_000;
    localparam int unsigned RESET_PULSE_US   = 10;
    localparam int unsigned RESET_PULSE_CYC  = ((CLK_HZ / 1_000_000) * RESET_PULSE_US);
    localparam int unsigned INIT_TIMEOUT_MS  = 2000;
    localparam int unsigned INIT_TIMEOUT_CYC = ((CLK_HZ / 1000) * INIT_TIMEOUT_MS);

    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam int          ADDR_W      = 8;
    localparam logic [7:0]  ADDR_CTRL   = 8'h00;
    localparam logic [7:0]  ADDR_MASK   = 8'h04;
    localparam logic [7:0]  ADDR_FLAGS  = 8'h08;
    localparam logic [7:0]  ADDR_STATUS = 8'h0c;

    localparam int          CTRL_W          = 4;
    localparam int          CTRL_TX_DIS     = 0;
    localparam int          CTRL_RX_DIS     = 1;
    localparam int          CTRL_SQ_DIS     = 2;
    localparam int          CTRL_STOP_SYNC  = 3;
    localparam logic [3:0]  CTRL_RESET      = 4'h0;

    // mask: [4:0] tx fault contributors, 5 tx fault, 6 rx los, 7 init, [15:8] alarm/warning
    // flags: 5 tx fault, 6 rx los, 7 init done, [15:8] alarm/warning
    localparam int          REG_W       = 16;
    localparam int          TXA_W       = 5;
    localparam int          AWF_W       = 8;
    localparam int          BIT_TXF     = 5;
    localparam int          BIT_LOS     = 6;
    localparam int          BIT_INIT    = 7;
    localparam int          AWF_LSB     = 8;
    localparam logic [15:0] MASK_RESET  = 16'h0000;
    localparam logic [15:0] FLAG_RESET  = 16'h0000;

    // status: 0 los live, 1 low power, [3:2] state, 4 int, [12:8] live tx alarms
    localparam int          ST_LOS      = 0;
    localparam int          ST_LPW      = 1;
    localparam int          ST_STATE    = 2;
    localparam int          ST_INT      = 4;
    localparam int          ST_TXA      = 8;

    // ------------------------------------------------------------------
    // synchronised pin vector
    // ------------------------------------------------------------------
    localparam int          PIN_W       = 7;
    localparam int          PIN_SCL     = 0;
    localparam int          PIN_SDA     = 1;
    localparam int          PIN_RSTN    = 2;
    localparam int          PIN_LPWN    = 3;
    localparam int          PIN_MRDY    = 4;
    localparam int          PIN_RXLP    = 5;
    localparam int          PIN_TXLOST  = 6;
    localparam logic [6:0]  PIN_IDLE    = 7'h0f;

    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        MFIT_RESET,
        MFIT_INIT,
        MFIT_READY
    } mfit_state_t;

endpackage

`default_nettype wire

// >>> hdl/mfit_top.sv
/*
 * module flag, interrupt and control-response logic with an axi4-lite
 * register slave. holds control, mask and latched flag registers, the
 * initialisation state, and drives the active-low interrupt and output enables.
 * assumes all condition inputs and the two-wire pins are asynchronous to aclk;
 * each passes two flip-flops before use.
 */
// Design decisions made here: the placing of the registers and register access over AXI4-Lite.
//
// Function
// R01 - initialisation ends within 2000 ms after power-on, plug or reset release
// R02 - reset pin low for at least 10 us starts a module reset
// R03 - any interrupt condition drives interrupt low within 200 ms
// R04 - interrupt released within 500 us after clear-on-read of its flag
// R05 - receive signal loss sets its bit and interrupt within 100 ms
// R06 - loss-of-signal status bit negates within 3 ms of condition gone
// R07 - transmit disable turns output off in 100 ms, back in 400 ms
// R08 - transmit fault sets its bit and interrupt within 200 ms
// R09 - alarm or warning sets its flag and interrupt within 200 ms
// R10 - mask set inhibits, mask cleared restores interrupt, each within 100 ms
// R11 - receive input loss squelches receive output within 15 ms
// R12 - transmit input loss squelches in 400 ms, resumes within 1.5 s
// R13 - receive output disable acts and releases within 100 ms
// R14 - one squelch disable governs both squelches, effective within 100 ms
// R15 - write deadlines count from the stop condition ending the write
// R16 - transmit fault set by power, lock or bias alarms
// R17 - each transmit fault contributor is individually maskable
// R18 - loss-of-signal follows the receive low power alarm exactly
// R19 - initialisation exits on interface ready with interrupt, or 2 s timeout
// R20 - low power mode keeps transmitters disabled besides software disable
// R21 - flags stay latched until read; interrupt while unmasked flag remains
`timescale 1ns/10ps
`default_nettype none

module mfit_top #(
    parameter int unsigned INIT_TIMEOUT_CYC = mfit_pkg::INIT_TIMEOUT_CYC
) (
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    input  wire logic                        ce,
    // axi4-lite slave
    input  wire logic [mfit_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [mfit_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    // module pins and conditions, all asynchronous
    input  wire logic                        scl,
    input  wire logic                        sda,
    input  wire logic                        module_reset_n,
    input  wire logic                        low_power_n,
    input  wire logic                        mgmt_ready,
    input  wire logic                        rx_low_power_alarm,
    input  wire logic                        tx_input_lost,
    input  wire logic [mfit_pkg::TXA_W-1:0]  tx_alarm,
    input  wire logic [mfit_pkg::AWF_W-1:0]  alarm_warn,
    // outputs
    output logic                             module_interrupt_n,
    output logic                             management_init_state,
    output logic                             tx_output_en,
    output logic                             rx_output_en,
    output logic                             tx_squelch,
    output logic                             rx_squelch
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [mfit_pkg::PIN_W-1:0]  pins1;
        logic [mfit_pkg::PIN_W-1:0]  pins2;
        logic                        sda_prev;
        logic [mfit_pkg::TXA_W-1:0]  txa1;
        logic [mfit_pkg::TXA_W-1:0]  txa2;
        logic [mfit_pkg::AWF_W-1:0]  awf1;
        logic [mfit_pkg::AWF_W-1:0]  awf2;
        mfit_pkg::mfit_state_t       state;
        logic [31:0]                 cnt;
        logic [31:0]                 rst_cnt;
        logic [mfit_pkg::CTRL_W-1:0] ctrl;
        logic [mfit_pkg::CTRL_W-1:0] ctrl_stage;
        logic [mfit_pkg::REG_W-1:0]  mask;
        logic [mfit_pkg::REG_W-1:0]  mask_stage;
        logic                        stage_dirty;
        logic [mfit_pkg::REG_W-1:0]  flags;
        logic [mfit_pkg::REG_W-1:0]  clr_pend;
        logic                        aw_got;
        logic                        w_got;
        logic [mfit_pkg::ADDR_W-1:0] awaddr;
        logic [31:0]                 wdata;
        logic [3:0]                  wstrb;
        logic                        awready;
        logic                        wready;
        logic                        bvalid;
        logic [1:0]                  bresp;
        logic                        arready;
        logic                        rvalid;
        logic [31:0]                 rdata;
        logic [1:0]                  rresp;
        logic                        int_n;
        logic                        init_out;
        logic                        tx_en;
        logic                        rx_en;
        logic                        tx_sq;
        logic                        rx_sq;
    } mfit_regs_t;

    mfit_regs_t r;
    mfit_regs_t next_r;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] mfit_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic mfit_mapped(input logic [mfit_pkg::ADDR_W-1:0] a);
        return (a == mfit_pkg::ADDR_CTRL) || (a == mfit_pkg::ADDR_MASK) ||
               (a == mfit_pkg::ADDR_FLAGS) || (a == mfit_pkg::ADDR_STATUS);
    endfunction

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic                       stop_evt;
        logic                       commit;
        logic                       rst_pin;
        logic                       low_pwr;
        logic                       live;
        logic                       txf_cond;
        logic                       sq_dis;
        logic [mfit_pkg::REG_W-1:0] set_v;
        logic [mfit_pkg::REG_W-1:0] clr_v;
        logic [31:0]                status;
        logic [31:0]                merged;

        {stop_evt, commit, rst_pin, low_pwr} = '0;
        {live, txf_cond, sq_dis, set_v, clr_v} = '0;
        {status, merged} = '0;
        next_r = r;

        // synchronisers: stage 1 is read only by stage 2
        next_r.pins1 = {tx_input_lost, rx_low_power_alarm, mgmt_ready, low_power_n,
                        module_reset_n, sda, scl};
        next_r.pins2 = r.pins1;
        next_r.txa1  = tx_alarm;
        next_r.txa2  = r.txa1;
        next_r.awf1  = alarm_warn;
        next_r.awf2  = r.awf1;
        next_r.sda_prev = r.pins2[mfit_pkg::PIN_SDA];

        // stop condition: data rises while clock high
        stop_evt = r.pins2[mfit_pkg::PIN_SCL] & r.pins2[mfit_pkg::PIN_SDA] & ~r.sda_prev;
        // staged writes and clears wait for the stop when enabled, else apply at once
        commit   = stop_evt | ~r.ctrl[mfit_pkg::CTRL_STOP_SYNC];                       // R15
        rst_pin  = ~r.pins2[mfit_pkg::PIN_RSTN];
        low_pwr  = ~r.pins2[mfit_pkg::PIN_LPWN];
        live     = (r.state == mfit_pkg::MFIT_READY);
        sq_dis   = r.ctrl[mfit_pkg::CTRL_SQ_DIS];

        // ---------------------------- flag sources
        txf_cond = |(r.txa2 & ~r.mask[mfit_pkg::TXA_W-1:0]);                          // R16 R17
        set_v = '0;
        if (live) begin
            set_v[mfit_pkg::BIT_TXF] = txf_cond;                                        // R08
            set_v[mfit_pkg::BIT_LOS] = r.pins2[mfit_pkg::PIN_RXLP];                     // R05 R18
            set_v[mfit_pkg::AWF_LSB +: mfit_pkg::AWF_W] = r.awf2;                       // R09
        end

        // ---------------------------- module reset pulse filter
        if (rst_pin) begin
            if (r.rst_cnt < mfit_pkg::RESET_PULSE_CYC) begin
                next_r.rst_cnt = r.rst_cnt + 32'h1;
            end
        end else begin
            next_r.rst_cnt = '0;
        end

        // ---------------------------- module state
        case (r.state)
            mfit_pkg::MFIT_RESET: begin
                next_r.cnt = '0;
                if (!rst_pin) begin
                    next_r.state = mfit_pkg::MFIT_INIT;                                 // R01
                end
            end
            mfit_pkg::MFIT_INIT: begin
                next_r.cnt = r.cnt + 32'h1;
                // ready raises the init flag, whose interrupt marks the exit
                if (r.pins2[mfit_pkg::PIN_MRDY] || r.cnt >= INIT_TIMEOUT_CYC - 1) begin  // R19 R01
                    next_r.state = mfit_pkg::MFIT_READY;
                    set_v[mfit_pkg::BIT_INIT] = 1'b1;
                end
            end
            mfit_pkg::MFIT_READY: begin
                next_r.cnt = '0;
            end
            default: begin
                next_r.state = mfit_pkg::MFIT_RESET;
            end
        endcase

        // ---------------------------- axi write channel
        if (s_axi_awvalid && r.awready) begin
            next_r.aw_got = 1'b1;
            next_r.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && r.wready) begin
            next_r.w_got = 1'b1;
            next_r.wdata = s_axi_wdata;
            next_r.wstrb = s_axi_wstrb;
        end
        if (r.bvalid && s_axi_bready) begin
            next_r.bvalid = 1'b0;
        end
        if (r.aw_got && r.w_got && !r.bvalid) begin
            next_r.aw_got = 1'b0;
            next_r.w_got  = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp  = mfit_mapped(r.awaddr) ? mfit_pkg::RESP_OKAY : mfit_pkg::RESP_SLVERR;
            if (r.awaddr == mfit_pkg::ADDR_CTRL) begin
                merged = mfit_merge({28'h0, r.ctrl_stage}, r.wdata, r.wstrb);
                next_r.ctrl_stage  = merged[mfit_pkg::CTRL_W-1:0];
                next_r.stage_dirty = 1'b1;
            end else if (r.awaddr == mfit_pkg::ADDR_MASK) begin
                merged = mfit_merge({16'h0, r.mask_stage}, r.wdata, r.wstrb);
                next_r.mask_stage  = merged[mfit_pkg::REG_W-1:0];
                next_r.stage_dirty = 1'b1;
            end
        end
        next_r.awready = !next_r.aw_got && !next_r.bvalid;
        next_r.wready  = !next_r.w_got && !next_r.bvalid;

        // ---------------------------- axi read channel
        status = '0;
        status[mfit_pkg::ST_LOS]      = r.pins2[mfit_pkg::PIN_RXLP];                   // R06 R18
        status[mfit_pkg::ST_LPW]      = low_pwr;
        status[mfit_pkg::ST_STATE +: 2] = r.state;
        status[mfit_pkg::ST_INT]      = ~r.int_n;
        status[mfit_pkg::ST_TXA +: mfit_pkg::TXA_W] = r.txa2;
        if (r.rvalid && s_axi_rready) begin
            next_r.rvalid = 1'b0;
        end
        if (s_axi_arvalid && r.arready) begin
            next_r.rvalid = 1'b1;
            next_r.rresp  = mfit_mapped(s_axi_araddr) ? mfit_pkg::RESP_OKAY : mfit_pkg::RESP_SLVERR;
            case (s_axi_araddr)
                mfit_pkg::ADDR_CTRL: begin
                    next_r.rdata = {28'h0, r.ctrl_stage};
                end
                mfit_pkg::ADDR_MASK: begin
                    next_r.rdata = {16'h0, r.mask_stage};
                end
                mfit_pkg::ADDR_FLAGS: begin
                    next_r.rdata    = {16'h0, r.flags};
                    // only bits seen set are cleared, so a later set survives
                    next_r.clr_pend = r.clr_pend | r.flags;                             // R04
                end
                mfit_pkg::ADDR_STATUS: begin
                    next_r.rdata = status;
                end
                default: begin
                    next_r.rdata = '0;
                end
            endcase
        end
        next_r.arready = !next_r.rvalid;

        // ---------------------------- commit staged control, mask and clears
        clr_v = '0;
        if (commit) begin
            clr_v = r.clr_pend;                                                         // R04 R15
            next_r.clr_pend = next_r.clr_pend & ~r.clr_pend;
            if (r.stage_dirty) begin
                next_r.ctrl        = r.ctrl_stage;                                      // R15
                next_r.mask        = r.mask_stage;                                      // R10
                next_r.stage_dirty = 1'b0;
            end
        end
        // set wins over a clear in the same cycle
        next_r.flags = (r.flags & ~clr_v) | set_v;                                      // R21

        // ---------------------------- module reset overrides
        if (r.rst_cnt >= mfit_pkg::RESET_PULSE_CYC) begin                                // R02
            next_r.state       = mfit_pkg::MFIT_RESET;
            next_r.cnt         = '0;
            next_r.ctrl        = mfit_pkg::CTRL_RESET;
            next_r.ctrl_stage  = mfit_pkg::CTRL_RESET;
            next_r.mask        = mfit_pkg::MASK_RESET;
            next_r.mask_stage  = mfit_pkg::MASK_RESET;
            next_r.stage_dirty = 1'b0;
            next_r.flags       = mfit_pkg::FLAG_RESET;
            next_r.clr_pend    = '0;
        end

        // ---------------------------- outputs, one cycle after their causes
        // interrupts suppressed outside ready; masks gate latched flags, mask [4:0] also the live tx alarms
        next_r.int_n    = ~(live && |(r.flags & ~r.mask));                              // R03 R21 R10
        next_r.init_out = (r.state == mfit_pkg::MFIT_INIT);
        // one squelch-disable bit governs both directions
        next_r.tx_sq    = r.pins2[mfit_pkg::PIN_TXLOST] & ~sq_dis;                      // R12 R14
        next_r.rx_sq    = r.pins2[mfit_pkg::PIN_RXLP] & ~sq_dis;                        // R11 R14
        next_r.tx_en    = live & ~r.ctrl[mfit_pkg::CTRL_TX_DIS] & ~low_pwr & ~next_r.tx_sq; // R07 R20
        next_r.rx_en    = live & ~r.ctrl[mfit_pkg::CTRL_RX_DIS] & ~next_r.rx_sq;        // R13
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r             <= '0;
            r.state       <= mfit_pkg::MFIT_INIT;
            r.pins1       <= mfit_pkg::PIN_IDLE;
            r.pins2       <= mfit_pkg::PIN_IDLE;
            r.sda_prev    <= 1'b1;
            r.ctrl        <= mfit_pkg::CTRL_RESET;
            r.ctrl_stage  <= mfit_pkg::CTRL_RESET;
            r.mask        <= mfit_pkg::MASK_RESET;
            r.mask_stage  <= mfit_pkg::MASK_RESET;
            r.flags       <= mfit_pkg::FLAG_RESET;
            r.int_n       <= 1'b1;
            r.init_out    <= 1'b1;
        end else if (ce) begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------------
    // ports
    // ------------------------------------------------------------------
    assign s_axi_awready         = r.awready;
    assign s_axi_wready          = r.wready;
    assign s_axi_bvalid          = r.bvalid;
    assign s_axi_bresp           = r.bresp;
    assign s_axi_arready         = r.arready;
    assign s_axi_rvalid          = r.rvalid;
    assign s_axi_rdata           = r.rdata;
    assign s_axi_rresp           = r.rresp;
    assign module_interrupt_n    = r.int_n;
    assign management_init_state = r.init_out;
    assign tx_output_en          = r.tx_en;
    assign rx_output_en          = r.rx_en;
    assign tx_squelch            = r.tx_sq;
    assign rx_squelch            = r.rx_sq;

endmodule

`default_nettype wire

// >>> verif/mfit_top_sva.sv
/* checker of mfit_top ports: init length, squelch, low power, module reset.
   bound to every mfit_top; one aclk domain. */
`timescale 1ns/10ps
`default_nettype none
module mfit_top_sva #(parameter int unsigned INIT_TIMEOUT_CYC = 200) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic module_reset_n,
    input wire logic low_power_n,
    input wire logic rx_low_power_alarm,
    input wire logic tx_input_lost,
    input wire logic module_interrupt_n,
    input wire logic management_init_state,
    input wire logic tx_output_en,
    input wire logic rx_output_en,
    input wire logic tx_squelch,
    input wire logic rx_squelch
);
    logic [31:0] init_cyc;
    logic [11:0] rst_cyc;
    // counters instead of long repetitions, which the tools unroll
    always_ff @(posedge aclk) begin
        init_cyc <= (!aresetn || !module_reset_n || !management_init_state) ? 32'h0 : init_cyc + 32'h1;
        rst_cyc  <= (!aresetn || module_reset_n) ? 12'h000 : rst_cyc + {11'h000, rst_cyc != 12'hfff};
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_init_bound: assert property (init_cyc <= INIT_TIMEOUT_CYC + 8) else $error("init too long");
    a_init_quiet: assert property (management_init_state |-> module_interrupt_n) else $error("int in init");
    a_rx_sq_off: assert property (rx_squelch && $past(rx_squelch) |-> !rx_output_en) else $error("rx on");
    a_tx_sq_off: assert property (tx_squelch && $past(tx_squelch) |-> !tx_output_en) else $error("tx on");
    a_lowpwr_tx: assert property (!low_power_n [*5] |=> !tx_output_en) else $error("tx on in low power");
    a_rxsq_clear: assert property (!rx_low_power_alarm [*8] |=> !rx_squelch) else $error("rx squelch");
    a_txsq_clear: assert property (!tx_input_lost [*8] |=> !tx_squelch) else $error("tx squelch");
    a_modrst_off: assert property (rst_cyc > 12'h4ec |-> !tx_output_en && !rx_output_en) else $error("on in reset");
endmodule
bind mfit_top mfit_top_sva #(.INIT_TIMEOUT_CYC(INIT_TIMEOUT_CYC)) i_mfit_top_sva (.*);
`default_nettype wire

// >>> verif/mfit_host.sv
/* two-wire host stand-in: one short frame per go pulse.
   lines idle high on the pull-ups; scl stands still between frames. */
`timescale 1ns/10ps
`default_nettype none
module mfit_host (
    input  wire logic go,
    output logic      scl,
    output logic      sda
);
    initial {scl, sda} = 2'b11;
    // start, two 64 ns clocks, then the stop that releases staged writes
    always @(posedge go) begin
        #34 sda = 1'b0;
        repeat (4) #32 scl = ~scl;
        #32 sda = 1'b1;
    end
endmodule
`default_nettype wire

// >>> verif/test_module_flag_interrupt_timing.sv
/* bench of mfit_top: axi4-lite master, random alarms and masks, pin stimulus.
   assumes mfit_host on the two-wire pins and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module test_module_flag_interrupt_timing;
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_total++; $display("CHECK FAILED %0t %h %h", $time, a, e); end end
    logic        aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, module_reset_n = 1'b1, low_power_n = 1'b1, go = 1'b0;
    logic        mgmt_ready = 1'b0, rx_low_power_alarm = 1'b0, tx_input_lost = 1'b0, scl, sda, s_axi_rready = 1'b0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, module_interrupt_n;
    logic        management_init_state, tx_output_en, rx_output_en, tx_squelch, rx_squelch;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, alarm_warn = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'hb495, d;
    logic [4:0]  tx_alarm = 5'h00;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [2:0]  c;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [5:0]  o;
    int          err_total = 0, n_checks = 0, i;
    mfit_top #(.INIT_TIMEOUT_CYC(200)) i_mfit_top (.*);
    mfit_host i_mfit_host (.*);
    always #4 aclk = ~aclk;
    // o: int_n, init, tx_en, rx_en, tx_sq, rx_sq; taken at the falling edge, settled
    always @(negedge aclk) o = {module_interrupt_n, management_init_state, tx_output_en,
                                rx_output_en, tx_squelch, rx_squelch};
    function automatic logic [31:0] lfsr(input logic [31:0] v); return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]}; endfunction
    function automatic logic txf(input logic [4:0] al, input logic [4:0] m); return |(al & ~m); endfunction
    task automatic w(input int n); repeat (n) @(posedge aclk); endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic ta, tw, tb;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, v, 3'h7};
        do begin
            @(negedge aclk);
            {ta, tw, tb, r} = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready, s_axi_bvalid, s_axi_bresp};
            @(posedge aclk);
            {s_axi_awvalid, s_axi_wvalid} <= {s_axi_awvalid & ~ta, s_axi_wvalid & ~tw};
        end while (!tb);
        s_axi_bready <= 1'b0;
        `CHK(r, mfit_pkg::RESP_OKAY)
    endtask
    // reads one word, compares the bits under m with e
    task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic ta, tv;
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do begin
            @(negedge aclk);
            {ta, tv, r, d} = {s_axi_arvalid & s_axi_arready, s_axi_rvalid, s_axi_rresp, s_axi_rdata};
            @(posedge aclk);
            s_axi_arvalid <= s_axi_arvalid & ~ta;
        end while (!tv);
        s_axi_rready <= 1'b0;
        `CHK(d & m, e)
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        w(4000);
        err_total++;
        end_of_test();
    end
    initial begin
        w(12);
        aresetn <= 1'b1;
        w(3);
        rc(mfit_pkg::ADDR_STATUS, 32'hc, 32'h4);
        mgmt_ready <= 1'b1;
        w(8);
        `CHK(o[5:4], 2'h0)
        rc(mfit_pkg::ADDR_FLAGS, 32'hffff, 32'h80);
        w(4);
        `CHK(o[5], 1'b1)
        for (i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            wr(mfit_pkg::ADDR_MASK, {27'h0, seed[4:0]});
            {alarm_warn, tx_alarm} <= {seed[15:8] | 8'h01, seed[20:16]};
            w(8);
            `CHK(o[5], 1'b0)
            {alarm_warn, tx_alarm} <= 13'h0;
            w(4);
            rc(mfit_pkg::ADDR_FLAGS, 32'hff20, {16'h0, seed[15:8] | 8'h01, 2'h0, txf(seed[20:16], seed[4:0]), 5'h0});
        end
        wr(mfit_pkg::ADDR_MASK, 32'hff00);
        alarm_warn <= 8'hff;
        w(8);
        `CHK(o[5], 1'b1)
        wr(mfit_pkg::ADDR_MASK, 32'h0);
        w(3);
        `CHK(o[5], 1'b0)
        {alarm_warn, rx_low_power_alarm} <= 9'h1;
        w(8);
        `CHK({o[2], o[0]}, 2'h1)
        rc(mfit_pkg::ADDR_STATUS, 32'h1, 32'h1);
        rc(mfit_pkg::ADDR_FLAGS, 32'h40, 32'h40);
        {rx_low_power_alarm, tx_input_lost} <= 2'h1;
        w(8);
        rc(mfit_pkg::ADDR_STATUS, 32'h1, 32'h0);
        `CHK({o[3], o[1]}, 2'h1)
        for (i = 0; i < 3; i++) begin
            c = 3'h4 + 3'(i);
            wr(mfit_pkg::ADDR_CTRL, {29'h0, c});
            w(4);
            `CHK(o[3:1], {~c[0], ~c[1], 1'b0})
        end
        {tx_input_lost, low_power_n} <= 2'h0;
        wr(mfit_pkg::ADDR_CTRL, 32'h0);
        w(6);
        `CHK(o[3], 1'b0)
        low_power_n <= 1'b1;
        rc(8'h40, 32'hffffffff, 32'h0);
        `CHK(r, mfit_pkg::RESP_SLVERR)
        wr(mfit_pkg::ADDR_CTRL, 32'h8);
        wr(mfit_pkg::ADDR_CTRL, 32'h9);
        w(8);
        `CHK(o[3], 1'b1)
        go <= 1'b1;
        w(1);
        go <= 1'b0;
        w(40);
        `CHK(o[3], 1'b0)
        {mgmt_ready, module_reset_n} <= 2'h0;
        w(1262);
        `CHK(o[3:2], 2'h0)
        module_reset_n <= 1'b1;
        w(8);
        `CHK(o[4], 1'b1)
        w(210);
        `CHK(o[4], 1'b0)
        end_of_test();
    end
endmodule
`default_nettype wire
